/* File: cmrr_pkg.sv */
// Constants, field layout and state type for the move/rotate/return execution block.
// Assumes a 14-bit instruction word presented on the core clock by a fetch stage.
//
// How it works
// RULE_01: decode 7-bit file address, one-bit destination
// RULE_02: move copies register to accumulator or back
// RULE_03: move sets zero flag from moved value
// RULE_04: idle only advances the program counter
// RULE_05: interrupt exit loads stack top, sets enable
// RULE_06: rotate left through carry, carry only
// RULE_07: rotate right through carry, carry only
// RULE_08: literal exit loads immediate into accumulator
// RULE_09: literal exit reloads counter, two cycles
// RULE_10: subroutine exit pops stack, two cycles
package cmrr_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int INSTR_W     = 14;
   localparam int ADDR_W      = 7;
   localparam int DATA_W      = 8;
   localparam int PC_W        = 13;
   localparam int STACK_DEPTH = 8;
   localparam int PTR_W       = 3;
   localparam int FILE_DEPTH  = 128;

   // ----------------------------------------------------------------
   // instruction field positions
   // ----------------------------------------------------------------
   localparam int OPC_MSB  = 13;
   localparam int OPC_LSB  = 8;
   localparam int PFX_LSB  = 10;
   localparam int DEST_BIT = 7;
   localparam int FILE_MSB = 6;
   localparam int LIT_MSB  = 7;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   localparam logic [5:0] OPC_FILE_MOVE = 6'h08;
   localparam logic [5:0] OPC_ROT_RIGHT = 6'h0C;
   localparam logic [5:0] OPC_ROT_LEFT  = 6'h0D;
   localparam logic [5:0] OPC_SYSTEM    = 6'h00;
   localparam logic [3:0] PFX_LIT_EXIT  = 4'hD;
   localparam logic [7:0] SYS_IDLE      = 8'h00;
   localparam logic [7:0] SYS_SUB_EXIT  = 8'h08;
   localparam logic [7:0] SYS_IRQ_EXIT  = 8'h09;
   localparam logic       DEST_ACC      = 1'h0;

   // ----------------------------------------------------------------
   // reset values and steps
   // ----------------------------------------------------------------
   localparam logic [PC_W-1:0]   PC_RESET   = 13'h0000;
   localparam logic [PC_W-1:0]   PC_STEP    = 13'h0001;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
   localparam logic [PTR_W-1:0]  PTR_RESET  = 3'h0;
   localparam logic [PTR_W-1:0]  PTR_STEP   = 3'h1;

   typedef enum logic [0:0] {
      ST_EXEC  = 1'h0,
      ST_FLUSH = 1'h1
   } cmrr_state_t;
endpackage : cmrr_pkg

/* File: cmrr_stack_if.sv */
// Carrier between the execution core and its return-address stack.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface cmrr_stack_if;
   import cmrr_pkg::*;
   logic            push;
   logic            pop;
   logic [PC_W-1:0] push_data;
   logic [PC_W-1:0] top;

   modport ctrl  (output push, output pop, output push_data, input top);
   modport store (input push, input pop, input push_data, output top);
endinterface : cmrr_stack_if
`default_nettype wire

/* File: cmrr_stack.sv */
// Eight-entry circular return-address stack.
// Assumes the core pops only on a return; overflow silently wraps, no error is flagged.
`timescale 1ns/1ps
`default_nettype none
module cmrr_stack
   import cmrr_pkg::*;
(
   input wire logic     i_ref_clk,
   input wire logic     i_reset_n,
   cmrr_stack_if.store  stk
);
   logic [PC_W-1:0]  mem [STACK_DEPTH];
   logic [PTR_W-1:0] ptr;
   logic [PTR_W-1:0] next_ptr;
   logic [PTR_W-1:0] wr_idx;
   logic             wr_en;

   assign stk.top = mem[ptr - PTR_STEP];

   // push and pop together replace the top entry, keeping depth unchanged
   always_comb begin
      next_ptr = ptr;
      wr_en    = stk.push;
      wr_idx   = ptr;
      if (stk.pop && stk.push) begin
         wr_idx = ptr - PTR_STEP;
      end else if (stk.pop) begin
         next_ptr = ptr - PTR_STEP;
      end else if (stk.push) begin
         next_ptr = ptr + PTR_STEP;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ptr <= PTR_RESET;
      end else begin
         ptr <= next_ptr;
      end
   end

   // entries carry no reset: contents are undefined until pushed
   always_ff @(posedge i_ref_clk) begin
      if (wr_en) begin
         mem[wr_idx] <= stk.push_data;
      end
   end
endmodule : cmrr_stack
`default_nettype wire

/* File: cmrr_core.sv */
// Execution of file move, idle, rotates through carry and the three return forms.
// Assumes one instruction word per cycle from a fetch stage on the same clock,
// held off by the fetch stage while o_busy is high.
`timescale 1ns/1ps
`default_nettype none
module cmrr_core
   import cmrr_pkg::*;
(
   input  wire logic               i_ref_clk,
   input  wire logic               i_reset_n,
   input  wire logic               i_instr_valid,
   input  wire logic [INSTR_W-1:0] i_instr,
   input  wire logic               i_push_valid,
   input  wire logic [PC_W-1:0]    i_push_addr,
   input  wire logic               i_irq_enable_clr,
   input  wire logic               i_file_wr_en,
   input  wire logic [ADDR_W-1:0]  i_file_wr_addr,
   input  wire logic [DATA_W-1:0]  i_file_wr_data,
   input  wire logic [ADDR_W-1:0]  i_peek_addr,
   output logic [PC_W-1:0]         o_program_counter,
   output logic [DATA_W-1:0]       o_acc,
   output logic                    o_carry,
   output logic                    o_zero,
   output logic                    o_global_irq_enable,
   output logic                    o_busy,
   output logic [DATA_W-1:0]       o_peek_data
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   cmrr_state_t      state, next_state;
   logic [PC_W-1:0]  next_pc;
   logic [DATA_W-1:0] next_acc, next_peek;
   logic             next_carry, next_zero, next_gie, next_busy;
   logic [DATA_W-1:0] file_mem [FILE_DEPTH];
   logic             wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;

   cmrr_stack_if stk ();

   cmrr_stack u_stack (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .stk       (stk.store)
   );

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic              take, dest_file;
   logic [5:0]        opc;
   logic [ADDR_W-1:0] faddr;
   logic [DATA_W-1:0] fval, lit, result;
   logic              is_move, is_rl, is_rr, is_lit, is_sub, is_irq, is_idle;

   assign take      = i_instr_valid && (state == ST_EXEC);
   assign opc       = i_instr[OPC_MSB:OPC_LSB];
   assign dest_file = i_instr[DEST_BIT] != DEST_ACC;          // [RULE_01]
   assign faddr     = i_instr[FILE_MSB:0];                    // [RULE_01]
   assign lit       = i_instr[LIT_MSB:0];
   assign fval      = file_mem[faddr];
   assign is_lit    = take && (i_instr[OPC_MSB:PFX_LSB] == PFX_LIT_EXIT);
   assign is_move   = take && !is_lit && (opc == OPC_FILE_MOVE);
   assign is_rl     = take && !is_lit && (opc == OPC_ROT_LEFT);
   assign is_rr     = take && !is_lit && (opc == OPC_ROT_RIGHT);
   assign is_sub    = take && !is_lit && (opc == OPC_SYSTEM) && (lit == SYS_SUB_EXIT);
   assign is_irq    = take && !is_lit && (opc == OPC_SYSTEM) && (lit == SYS_IRQ_EXIT);
   // unassigned codes fall through as idle, so a bad fetch never stalls the core
   assign is_idle   = take && !(is_lit || is_move || is_rl || is_rr || is_sub || is_irq);

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_state    = ST_EXEC;
      next_pc       = o_program_counter;
      next_acc      = o_acc;
      next_carry    = o_carry;
      next_zero     = o_zero;
      next_gie      = o_global_irq_enable && !i_irq_enable_clr;
      result        = fval;
      wr_en         = i_file_wr_en;
      wr_addr       = i_file_wr_addr;
      wr_data       = i_file_wr_data;
      stk.pop       = 1'h0;
      stk.push      = i_push_valid;
      stk.push_data = i_push_addr;
      if (is_move || is_rl || is_rr) begin
         next_pc = o_program_counter + PC_STEP;
         if (is_move) begin
            result    = fval;                                  // [RULE_02]
            next_zero = (fval == DATA_ZERO);                   // [RULE_03]
         end else if (is_rl) begin
            result     = {fval[DATA_W-2:0], o_carry};          // [RULE_06]
            next_carry = fval[DATA_W-1];                       // [RULE_06]
         end else begin
            result     = {o_carry, fval[DATA_W-1:1]};          // [RULE_07]
            next_carry = fval[0];                              // [RULE_07]
         end
         // core writes win over the side write port in the same cycle
         if (dest_file) begin
            wr_en   = 1'h1;                                    // [RULE_02]
            wr_addr = faddr;
            wr_data = result;
         end else begin
            next_acc = result;                                 // [RULE_02]
         end
      end else if (is_lit || is_sub || is_irq) begin
         next_pc    = stk.top;                                 // [RULE_05] [RULE_09] [RULE_10]
         stk.pop    = 1'h1;                                    // [RULE_10]
         next_state = ST_FLUSH;                                // [RULE_09] [RULE_10]
         if (is_lit) begin
            next_acc = lit;                                    // [RULE_08]
         end
         if (is_irq) begin
            next_gie = 1'h1;                                   // [RULE_05]
         end
      end else if (is_idle) begin
         next_pc = o_program_counter + PC_STEP;                // [RULE_04]
      end
      next_busy = (next_state == ST_FLUSH);
      next_peek = (wr_en && (wr_addr == i_peek_addr)) ? wr_data : file_mem[i_peek_addr];
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state               <= ST_EXEC;
         o_program_counter   <= PC_RESET;
         o_acc               <= DATA_RESET;
         o_carry             <= 1'h0;
         o_zero              <= 1'h0;
         o_global_irq_enable <= 1'h0;
         o_busy              <= 1'h0;
         o_peek_data         <= DATA_RESET;
      end else begin
         state               <= next_state;
         o_program_counter   <= next_pc;
         o_acc               <= next_acc;
         o_carry             <= next_carry;
         o_zero              <= next_zero;
         o_global_irq_enable <= next_gie;
         o_busy              <= next_busy;
         o_peek_data         <= next_peek;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (wr_en) begin
         file_mem[wr_addr] <= wr_data;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   move_to_acc_a: assert property ( // [RULE_02]
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      is_move && !dest_file |=> o_acc == $past(fval))
      else $error("move to accumulator lost the value");

   move_zero_a: assert property ( // [RULE_03]
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      is_move |=> (o_zero == ($past(fval) == DATA_ZERO)) && $stable(o_carry))
      else $error("move zero flag wrong");

   move_back_a: assert property ( // [RULE_02]
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      is_move && dest_file && (faddr == i_peek_addr) |=> o_peek_data == $past(fval))
      else $error("move back changed the register");

   idle_hold_a: assert property ( // [RULE_04]
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      is_idle && !i_irq_enable_clr |=> o_program_counter == $past(o_program_counter) + PC_STEP
         && $stable(o_acc) && $stable(o_carry) && $stable(o_zero)
         && $stable(o_global_irq_enable) && !o_busy)
      else $error("idle changed state");

   irq_exit_a: assert property ( // [RULE_05]
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      is_irq |=> o_global_irq_enable && (o_program_counter == $past(stk.top))
         && $stable(o_zero) && $stable(o_carry))
      else $error("interrupt exit wrong");

   rot_left_a: assert property ( // [RULE_06]
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      is_rl && !dest_file |=> o_acc == {$past(fval[DATA_W-2:0]), $past(o_carry)}
         && o_carry == $past(fval[DATA_W-1]) && $stable(o_zero))
      else $error("rotate left wrong");

   rot_right_a: assert property ( // [RULE_07]
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      is_rr && !dest_file |=> o_acc == {$past(o_carry), $past(fval[DATA_W-1:1])}
         && o_carry == $past(fval[0]) && $stable(o_zero))
      else $error("rotate right wrong");

   lit_value_a: assert property ( // [RULE_08]
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      is_lit |=> o_acc == $past(lit) && $stable(o_zero) && $stable(o_carry))
      else $error("literal exit value wrong");

   lit_cycles_a: assert property ( // [RULE_09]
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      is_lit |=> o_busy && (o_program_counter == $past(stk.top)) ##1 !o_busy)
      else $error("literal exit not two cycles");

   sub_exit_a: assert property ( // [RULE_10]
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      is_sub |=> o_busy && (o_program_counter == $past(stk.top)) && $stable(o_acc)
         ##1 !o_busy && $stable(o_program_counter))
      else $error("subroutine exit wrong");

   // a word offered in the dead cycle after a return must leave no trace
   flush_hold_a: assert property ( // [RULE_09] [RULE_10]
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      o_busy |=> $stable(o_program_counter) && $stable(o_acc) && $stable(o_carry)
         && $stable(o_zero) && !o_busy)
      else $error("instruction taken in dead cycle");

   dest_keep_a: assert property ( // [RULE_01]
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (is_move || is_rl || is_rr) && dest_file |=> $stable(o_acc))
      else $error("file destination touched the accumulator");
endmodule : cmrr_core
`default_nettype wire

/* File: cpu_move_rotate_return_ops_test.sv */
// Self-checking bench for the move, rotate and return execution core.
// Assumes cmrr_pkg, the stack carrier, the stack and the core are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cpu_move_rotate_return_ops_test
   import cmrr_pkg::*;
;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic                ref_clk;
   logic                reset_n;
   logic                instr_valid;
   logic [INSTR_W-1:0]  instr;
   logic                push_valid;
   logic [PC_W-1:0]     push_addr;
   logic                irq_enable_clr;
   logic                file_wr_en;
   logic [ADDR_W-1:0]   file_wr_addr;
   logic [DATA_W-1:0]   file_wr_data;
   logic [ADDR_W-1:0]   peek_addr;
   logic [PC_W-1:0]     pc;
   logic [DATA_W-1:0]   acc;
   logic                carry;
   logic                zero;
   logic                global_irq_enable;
   logic                busy;
   logic [DATA_W-1:0]   peek;
   int                  bad_count;
   int                  num_checks;
   int                  cycles;

   typedef struct packed {
      logic [13:0] ins;
      logic [7:0]  fv;
      logic [7:0]  acc;
      logic [7:0]  peek;
      logic        c;
      logic        z;
   } cmrr_row_t;

   // carry runs on from row to row, so the rows only hold in this order
   cmrr_row_t rows [0:7] = '{
      '{14'h0805, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1},
      '{14'h08FF, 8'hA5, 8'h00, 8'hA5, 1'b0, 1'b0},
      '{14'h0D10, 8'h81, 8'h02, 8'h81, 1'b1, 1'b0},
      '{14'h0D91, 8'h40, 8'h02, 8'h81, 1'b0, 1'b0},
      '{14'h0C80, 8'h01, 8'h02, 8'h00, 1'b1, 1'b0},
      '{14'h0C12, 8'h02, 8'h81, 8'h02, 1'b0, 1'b0},
      '{14'h0000, 8'h3C, 8'h81, 8'h3C, 1'b0, 1'b0},
      '{14'h0893, 8'h00, 8'h81, 8'h00, 1'b0, 1'b1}};

   cmrr_core dut (
      .i_ref_clk           (ref_clk),
      .i_reset_n           (reset_n),
      .i_instr_valid       (instr_valid),
      .i_instr             (instr),
      .i_push_valid        (push_valid),
      .i_push_addr         (push_addr),
      .i_irq_enable_clr    (irq_enable_clr),
      .i_file_wr_en        (file_wr_en),
      .i_file_wr_addr      (file_wr_addr),
      .i_file_wr_data      (file_wr_data),
      .i_peek_addr         (peek_addr),
      .o_program_counter   (pc),
      .o_acc               (acc),
      .o_carry             (carry),
      .o_zero              (zero),
      .o_global_irq_enable (global_irq_enable),
      .o_busy              (busy),
      .o_peek_data         (peek)
   );

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wr_file(input logic [6:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      file_wr_en   <= 1'b1;
      file_wr_addr <= a;
      file_wr_data <= d;
      @(posedge ref_clk);
      file_wr_en   <= 1'b0;
   endtask : wr_file

   task automatic push(input logic [12:0] a);
      @(posedge ref_clk);
      push_valid <= 1'b1;
      push_addr  <= a;
      @(posedge ref_clk);
      push_valid <= 1'b0;
   endtask : push

   // outputs are looked at 1 ns after the taking edge, once its updates land
   task automatic exec(input logic [13:0] ins);
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      instr       <= ins;
      peek_addr   <= ins[6:0];
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      #1;
   endtask : exec

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      bad_count = 0; num_checks = 0; cycles = 0;
      reset_n = 1'b0; instr_valid = 1'b0; instr = 14'h0000;
      push_valid = 1'b0; push_addr = 13'h0000; irq_enable_clr = 1'b0;
      file_wr_en = 1'b0; file_wr_addr = 7'h00; file_wr_data = 8'h00; peek_addr = 7'h00;
      repeat (7) @(posedge ref_clk);
      #1;
      chk("reset pc", 16'h0000, 16'(pc));
      chk("reset flags", 16'h0000, 16'({acc, carry, zero, global_irq_enable, busy}));
      @(posedge ref_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         wr_file(rows[i].ins[6:0], rows[i].fv);
         exec(rows[i].ins);
         chk("acc", 16'(rows[i].acc), 16'(acc));
         chk("file", 16'(rows[i].peek), 16'(peek));
         chk("carry", 16'(rows[i].c), 16'(carry));
         chk("zero", 16'(rows[i].z), 16'(zero));
         chk("pc", 16'(i + 1), 16'(pc));
      end
      // literal exit, with a word offered during its dead cycle that must be ignored
      push(13'h0ABC);
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      instr       <= 14'h34FF;
      @(posedge ref_clk);
      instr       <= 14'h0000;
      #1;
      chk("lit acc", 16'h00FF, 16'(acc));
      chk("lit pc", 16'h0ABC, 16'(pc));
      chk("lit busy", 16'h0001, 16'(busy));
      chk("lit flags", 16'h0001, 16'({carry, zero}));
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      #1;
      chk("dead pc", 16'h0ABC, 16'(pc));
      chk("dead busy", 16'h0000, 16'(busy));
      // two nested subroutine exits pop in reverse order
      push(13'h0100);
      push(13'h0200);
      exec(14'h0008);
      chk("ret pc", 16'h0200, 16'(pc));
      chk("ret busy", 16'h0001, 16'(busy));
      @(posedge ref_clk);
      exec(14'h0008);
      chk("ret2 pc", 16'h0100, 16'(pc));
      chk("ret flags", 16'h000A, 16'({acc == 8'hFF, carry, zero, global_irq_enable}));
      // interrupt exit sets the enable and keeps the flags
      push(13'h1FFF);
      exec(14'h0009);
      chk("irq pc", 16'h1FFF, 16'(pc));
      chk("irq gie", 16'h0001, 16'(global_irq_enable));
      chk("irq flags", 16'h0001, 16'({carry, zero}));
      @(posedge ref_clk);
      irq_enable_clr <= 1'b1;
      @(posedge ref_clk);
      irq_enable_clr <= 1'b0;
      #1;
      chk("gie clr", 16'h0000, 16'(global_irq_enable));
      // reset again in mid-run
      @(posedge ref_clk);
      reset_n <= 1'b0;
      #1;
      chk("rst2 pc", 16'h0000, 16'(pc));
      chk("rst2 regs", 16'h0000, 16'({acc, carry, zero, global_irq_enable, busy}));
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      exec(14'h0000);
      chk("rst2 idle pc", 16'h0001, 16'(pc));
      give_verdict();
   end
endmodule : cpu_move_rotate_return_ops_test
`default_nettype wire
